// ==== shared/nac_pkg.sv ====
// constants shared by the nonvolatile self-access controller
package nac_pkg;

   // ----------------------------------------------------------------
   // special register map
   // ----------------------------------------------------------------
   localparam logic [8:0] ADDR_DATA_LOW = 9'h188;
   localparam logic [8:0] ADDR_DATA_HIGH = 9'h189;
   localparam logic [8:0] ADDR_ADDR_LOW = 9'h18A;
   localparam logic [8:0] ADDR_ADDR_HIGH = 9'h18B;
   localparam logic [8:0] ADDR_CONTROL = 9'h18C;
   localparam logic [8:0] ADDR_UNLOCK = 9'h18D;

   // ----------------------------------------------------------------
   // memory_access_control fields
   // ----------------------------------------------------------------
   localparam int SEL_BIT = 7;
   localparam int ABORT_BIT = 3;
   localparam int PERMIT_BIT = 2;
   localparam int WSTART_BIT = 1;
   localparam int RSTART_BIT = 0;
   localparam logic [2:0] CTRL_UNUSED = 3'h0;
   localparam logic [7:0] READ_ZERO = 8'h00;
   localparam logic [1:0] DATA_HIGH_PAD = 2'h0;

   // ----------------------------------------------------------------
   // unlock key sequence
   // ----------------------------------------------------------------
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;

   // ----------------------------------------------------------------
   // array geometry
   // ----------------------------------------------------------------
   localparam int EE_DEPTH = 64;
   localparam int EE_AW = 6;
   localparam int EE_DW = 8;
   localparam int FL_DEPTH = 2048;
   localparam int FL_AW = 11;
   localparam int FL_DW = 14;
   localparam int FL_HIGH_W = FL_DW - EE_DW;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int CLKS_PER_INSTR = 4;
   localparam int DIV_W = 4;
   localparam int FL_READ_INSTR = 2;
   localparam int EE_WRITE_TIME_NS = 4000000;
   localparam int FL_WRITE_TIME_NS = 2000000;
   localparam int EE_WRITE_CYCLES = (EE_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FL_WRITE_CYCLES = (FL_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ==== hdl/nac_nvm_array.sv ====
// storage array with registered read port and single write port
`timescale 1ns/1ps
module nac_nvm_array #(
   parameter int DW = 8,
   parameter int DEPTH = 64,
   parameter int AW = 6
) (
   input wire logic clk,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data
);

   typedef struct packed {
      logic [DW-1:0] rd_data;
   } nac_array_state_t;

   logic [DW-1:0] cells [DEPTH];
   nac_array_state_t r;
   nac_array_state_t next_r;

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   // read returns old contents if the same cell is written that cycle
   always_comb begin
      next_r = r;
      if (rd_en) begin
         next_r.rd_data = cells[rd_addr];
      end
   end

   always_ff @(posedge clk) begin
      r <= next_r;
      if (wr_en) begin
         cells[wr_addr] <= wr_data;
      end
   end

   assign rd_data = r.rd_data;

endmodule

// ==== hdl/nac_unlock_seq.sv ====
// key sequence tracker behind the write_unlock_port
`timescale 1ns/1ps
module nac_unlock_seq (
   input wire logic clk,
   input wire logic reset,
   input wire logic clear,
   input wire logic wr_en,
   input wire logic wr_unlock,
   input wire logic [7:0] wr_data,
   output logic armed
);

   typedef struct packed {
      logic got_first;
      logic got_both;
   } nac_unlock_state_t;

   nac_unlock_state_t r;
   nac_unlock_state_t next_r;

   // ----------------------------------------------------------------
   // sequence tracking
   // ----------------------------------------------------------------
   // any other register write breaks the sequence, so a stray
   // write between the keys and the trigger disarms
   always_comb begin
      next_r = r;
      if (clear) begin
         next_r = '0;
      end else if (wr_en) begin
         next_r = '0;
         if (wr_unlock && wr_data == nac_pkg::KEY_FIRST) begin
            next_r.got_first = 1'b1;
         end else if (wr_unlock && wr_data == nac_pkg::KEY_SECOND && r.got_first) begin
            next_r.got_both = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign armed = r.got_both;

endmodule

// ==== hdl/nac_nvm_self_access_controller.sv ====
// nonvolatile self-access controller: registers, read and write sequencing
`timescale 1ns/1ps
module nac_nvm_self_access_controller #(
   parameter int unsigned EE_WRITE_CYCLES = nac_pkg::EE_WRITE_CYCLES,
   parameter int unsigned FL_WRITE_CYCLES = nac_pkg::FL_WRITE_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic pin_reset,
   input wire logic watchdog_reset,
   input wire logic [8:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic cpu_stall,
   output logic irq_defer,
   output logic write_done_set,
   output logic write_busy
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RD_EE,
      ST_RD_FL,
      ST_ERASE,
      ST_PROG
   } nac_state_t;

   typedef struct packed {
      nac_state_t state;
      logic [nac_pkg::DIV_W-1:0] div;
      logic [1:0] rd_ticks;
      logic [31:0] cnt;
      logic [7:0] data_low;
      logic [nac_pkg::FL_HIGH_W-1:0] data_high;
      logic [7:0] addr_low;
      logic [7:0] addr_high;
      logic sel;
      logic abort;
      logic permit;
      logic wstart;
      logic rstart;
      logic wr_flash;
      logic [nac_pkg::FL_AW-1:0] wr_addr;
      logic [nac_pkg::FL_DW-1:0] wr_data;
      logic stall;
      logic defer;
      logic done;
      logic [7:0] rdata;
   } nac_ctrl_state_t;

   nac_ctrl_state_t r;
   nac_ctrl_state_t next_r;

   logic soft_reset;
   logic armed;
   logic tick;
   logic busy;
   logic ctrl_wr;
   logic sel_now;
   logic [31:0] half_len;
   logic [31:0] full_len;
   logic ee_rd_en;
   logic fl_rd_en;
   logic ee_wr_en;
   logic fl_wr_en;
   logic [nac_pkg::FL_DW-1:0] arr_wr_data;
   logic [nac_pkg::EE_DW-1:0] ee_q;
   logic [nac_pkg::FL_DW-1:0] fl_q;
   logic [nac_pkg::EE_AW-1:0] ee_rd_addr;
   logic [nac_pkg::FL_AW-1:0] fl_rd_addr;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // the 16-bit flash address, cut to the 11 bits that exist
   function automatic logic [nac_pkg::FL_AW-1:0] flash_addr(
      input logic [7:0] hi,
      input logic [7:0] lo
   );
      logic [15:0] full;
      full = {hi, lo};
      return full[nac_pkg::FL_AW-1:0];
   endfunction

   assign soft_reset = pin_reset | watchdog_reset;
   assign tick = (r.div == nac_pkg::DIV_W'(nac_pkg::CLKS_PER_INSTR - 1));
   assign busy = (r.state != ST_IDLE);
   assign ctrl_wr = sfr_wr && (sfr_addr == nac_pkg::ADDR_CONTROL);
   assign sel_now = busy ? r.sel : sfr_wdata[nac_pkg::SEL_BIT];
   assign full_len = r.wr_flash ? FL_WRITE_CYCLES : EE_WRITE_CYCLES;
   // compares below add rather than subtract, so tiny lengths cannot wrap
   assign half_len = full_len >> 1;
   assign ee_rd_addr = r.addr_low[nac_pkg::EE_AW-1:0];
   assign fl_rd_addr = flash_addr(r.addr_high, r.addr_low);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   // byte-wide data eeprom
   nac_nvm_array #(
      .DW(nac_pkg::EE_DW),
      .DEPTH(nac_pkg::EE_DEPTH),
      .AW(nac_pkg::EE_AW)
   ) u_ee (
      .clk(clk),
      .rd_en(ee_rd_en),
      .rd_addr(ee_rd_addr),
      .rd_data(ee_q),
      .wr_en(ee_wr_en),
      .wr_addr(r.wr_addr[nac_pkg::EE_AW-1:0]),
      .wr_data(arr_wr_data[nac_pkg::EE_DW-1:0])
   );

   nac_nvm_array #(
      .DW(nac_pkg::FL_DW),
      .DEPTH(nac_pkg::FL_DEPTH),
      .AW(nac_pkg::FL_AW)
   ) u_fl (
      .clk(clk),
      .rd_en(fl_rd_en),
      .rd_addr(fl_rd_addr),
      .rd_data(fl_q),
      .wr_en(fl_wr_en),
      .wr_addr(r.wr_addr),
      .wr_data(arr_wr_data)
   );

   nac_unlock_seq u_unlock (
      .clk(clk),
      .reset(reset),
      .clear(soft_reset),
      .wr_en(sfr_wr),
      .wr_unlock(sfr_addr == nac_pkg::ADDR_UNLOCK),
      .wr_data(sfr_wdata),
      .armed(armed)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_r = r;
      ee_rd_en = 1'b0;
      fl_rd_en = 1'b0;
      ee_wr_en = 1'b0;
      fl_wr_en = 1'b0;
      arr_wr_data = r.wr_data;
      next_r.done = 1'b0;
      next_r.div = tick ? '0 : r.div + 1'b1;
      if (tick) begin
         next_r.defer = 1'b0;
      end

      // register writes from the core
      if (sfr_wr) begin
         unique case (sfr_addr)
            nac_pkg::ADDR_DATA_LOW: begin
               next_r.data_low = sfr_wdata;
            end
            nac_pkg::ADDR_DATA_HIGH: begin
               next_r.data_high = sfr_wdata[nac_pkg::FL_HIGH_W-1:0];
            end
            nac_pkg::ADDR_ADDR_LOW: begin
               next_r.addr_low = sfr_wdata;
            end
            nac_pkg::ADDR_ADDR_HIGH: begin
               next_r.addr_high = sfr_wdata;
            end
            nac_pkg::ADDR_CONTROL: begin
               next_r.sel = sel_now;
               next_r.permit = sfr_wdata[nac_pkg::PERMIT_BIT];
               next_r.abort = sfr_wdata[nac_pkg::ABORT_BIT];
            end
            default: begin
            end
         endcase
      end

      // starting an access; zeros in the start bits do nothing
      if (ctrl_wr && !busy) begin
         if (sfr_wdata[nac_pkg::RSTART_BIT]) begin
            next_r.rstart = 1'b1;
            if (sel_now) begin
               fl_rd_en = 1'b1;
               next_r.rd_ticks = '0;
               next_r.state = ST_RD_FL;
            end else begin
               ee_rd_en = 1'b1;
               next_r.state = ST_RD_EE;
            end
         end else if (sfr_wdata[nac_pkg::WSTART_BIT] && r.permit && armed) begin
            next_r.wstart = 1'b1;
            next_r.wr_flash = sel_now;
            next_r.cnt = '0;
            next_r.state = ST_ERASE;
            // latched so later register writes cannot disturb the cycle
            if (sel_now) begin
               // 14-bit word from both data registers
               next_r.wr_addr = flash_addr(r.addr_high, r.addr_low);
               next_r.wr_data = {r.data_high, r.data_low};
               next_r.stall = 1'b1;
            end else begin
               next_r.wr_addr = nac_pkg::FL_AW'(r.addr_low[nac_pkg::EE_AW-1:0]);
               next_r.wr_data = nac_pkg::FL_DW'(r.data_low);
            end
         end
      end

      // sequencing
      unique case (r.state)
         ST_IDLE: begin
         end
         ST_RD_EE: begin
            next_r.data_low = ee_q;
            next_r.rstart = 1'b0;
            next_r.state = ST_IDLE;
         end
         ST_RD_FL: begin
            // word valid after two instruction cycles
            if (tick) begin
               if (r.rd_ticks == 2'(nac_pkg::FL_READ_INSTR - 1)) begin
                  next_r.data_low = fl_q[nac_pkg::EE_DW-1:0];
                  next_r.data_high = fl_q[nac_pkg::FL_DW-1:nac_pkg::EE_DW];
                  next_r.rstart = 1'b0;
                  next_r.state = ST_IDLE;
               end else begin
                  next_r.rd_ticks = r.rd_ticks + 2'h1;
               end
            end
         end
         ST_ERASE: begin
            next_r.cnt = r.cnt + 32'h0000_0001;
            if (r.cnt + 32'h0000_0001 >= half_len) begin
               arr_wr_data = '1;
               ee_wr_en = !r.wr_flash;
               fl_wr_en = r.wr_flash;
               next_r.cnt = '0;
               next_r.state = ST_PROG;
            end
         end
         ST_PROG: begin
            next_r.cnt = r.cnt + 32'h0000_0001;
            if (r.cnt + half_len + 32'h0000_0001 >= full_len) begin
               ee_wr_en = !r.wr_flash;
               fl_wr_en = r.wr_flash;
               next_r.wstart = 1'b0;
               next_r.abort = 1'b0;
               next_r.done = 1'b1;
               next_r.defer = r.wr_flash;
               next_r.stall = 1'b0;
               next_r.state = ST_IDLE;
            end
         end
         default: begin
            next_r.state = ST_IDLE;
         end
      endcase

      // no bulk erase path exists
      // pin or watchdog reset ends any access early
      if (soft_reset) begin
         // abort flag when write cut short
         if (r.state == ST_ERASE || r.state == ST_PROG) begin
            next_r.abort = 1'b1;
         end
         next_r.permit = 1'b0;
         next_r.wstart = 1'b0;
         next_r.rstart = 1'b0;
         next_r.stall = 1'b0;
         next_r.defer = 1'b0;
         next_r.done = 1'b0;
         next_r.state = ST_IDLE;
         ee_wr_en = 1'b0;
         fl_wr_en = 1'b0;
      end

      // ----------------------------------------------------------------
      // register read-back, one clock behind the address
      // ----------------------------------------------------------------
      unique case (sfr_addr)
         nac_pkg::ADDR_DATA_LOW: begin
            next_r.rdata = r.data_low;
         end
         // unused high data bits read zero
         nac_pkg::ADDR_DATA_HIGH: begin
            next_r.rdata = {nac_pkg::DATA_HIGH_PAD, r.data_high};
         end
         nac_pkg::ADDR_ADDR_LOW: begin
            next_r.rdata = r.addr_low;
         end
         nac_pkg::ADDR_ADDR_HIGH: begin
            next_r.rdata = r.addr_high;
         end
         nac_pkg::ADDR_CONTROL: begin
            next_r.rdata = {r.sel, nac_pkg::CTRL_UNUSED, r.abort, r.permit, r.wstart, r.rstart};
         end
         default: begin
            next_r.rdata = nac_pkg::READ_ZERO;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign cpu_stall = r.stall;
   assign irq_defer = r.stall | r.defer;
   assign write_done_set = r.done;
   assign write_busy = r.wstart;
   assign sfr_rdata = r.rdata;

endmodule

// ==== tb/nac_nvm_properties.sv ====
// port-level checker of the nonvolatile self-access controller
`timescale 1ns/1ps
module nac_nvm_properties #(
   parameter int unsigned EE_WRITE_CYCLES = 20,
   parameter int unsigned FL_WRITE_CYCLES = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic pin_reset,
   input wire logic watchdog_reset,
   input wire logic [8:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic cpu_stall,
   input wire logic irq_defer,
   input wire logic write_done_set,
   input wire logic write_busy
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // ------------------------------------------------
   // busy length counter
   // ------------------------------------------------
   logic [31:0] busy_cnt;
   always_ff @(posedge clk) begin
      if (reset) begin
         busy_cnt <= 32'h0000_0000;
      end else begin
         busy_cnt <= write_busy ? busy_cnt + 32'h0000_0001 : 32'h0000_0000;
      end
   end
   // ------------------------------------------------
   // assertions
   // ------------------------------------------------
   AST_UNLOCK_READS_ZERO: assert property (
      $past(sfr_addr) == nac_pkg::ADDR_UNLOCK |-> sfr_rdata == nac_pkg::READ_ZERO)
      else $error("unlock port read not zero");
   AST_CTRL_PAD_ZERO: assert property (
      $past(sfr_addr) == nac_pkg::ADDR_CONTROL |-> sfr_rdata[6:4] == nac_pkg::CTRL_UNUSED)
      else $error("control bits 6-4 not zero");
   AST_DATA_HIGH_PAD: assert property (
      $past(sfr_addr) == nac_pkg::ADDR_DATA_HIGH |-> sfr_rdata[7:6] == nac_pkg::DATA_HIGH_PAD)
      else $error("data high pad bits not zero");
   AST_START_NEEDS_CTRL_WRITE: assert property (
      $rose(write_busy) |-> $past(sfr_wr) && $past(sfr_addr) == nac_pkg::ADDR_CONTROL
         && $past(sfr_wdata[1]))
      else $error("write began without a start write");
   AST_STALL_WITH_WRITE: assert property (
      $rose(cpu_stall) |-> $rose(write_busy))
      else $error("stall not tied to write start");
   AST_DEFER_WHILE_STALL: assert property (
      cpu_stall |-> irq_defer)
      else $error("interrupts not held during stall");
   AST_DEFER_RELEASE: assert property (
      $fell(cpu_stall) |-> ##[0:4] !irq_defer)
      else $error("interrupt hold not released");
   AST_DONE_ENDS_WRITE: assert property (
      write_done_set |-> $fell(write_busy) ##1 !write_done_set)
      else $error("done pulse not at write end");
   AST_SELF_TIMED_LEN: assert property (
      write_done_set |-> busy_cnt + 1 >= ($past(cpu_stall) ? FL_WRITE_CYCLES : EE_WRITE_CYCLES)
         && busy_cnt <= ($past(cpu_stall) ? FL_WRITE_CYCLES : EE_WRITE_CYCLES) + 1)
      else $error("write length off");
   AST_RESET_ABORTS: assert property (
      pin_reset || watchdog_reset |=> !write_busy && !cpu_stall && !write_done_set)
      else $error("write survived pin or watchdog reset");
   COV_EE_DONE: cover property (write_done_set && !$past(cpu_stall));
   COV_FL_DONE: cover property ($fell(cpu_stall) && write_done_set);
   COV_ABORT: cover property ((pin_reset || watchdog_reset) && write_busy);
endmodule

bind nac_nvm_self_access_controller nac_nvm_properties #(
   .EE_WRITE_CYCLES(EE_WRITE_CYCLES),
   .FL_WRITE_CYCLES(FL_WRITE_CYCLES)
) u_nac_nvm_properties (.clk(clk), .reset(reset), .pin_reset(pin_reset),
   .watchdog_reset(watchdog_reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
   .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_stall(cpu_stall),
   .irq_defer(irq_defer), .write_done_set(write_done_set), .write_busy(write_busy));

// ==== tb/nac_core_model.sv ====
// processor core model running firmware accesses on the special registers
`timescale 1ns/1ps
module nac_core_model (
   input wire logic clk,
   input wire logic [1:0] pace,
   output logic [8:0] sfr_addr,
   output logic sfr_wr,
   output logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic cpu_stall,
   input wire logic write_done_set
);
   logic done_flag = 1'b0;
   initial begin
      sfr_addr = 9'h000;
      sfr_wr = 1'b0;
      sfr_wdata = 8'h00;
   end
   // flag lives with the core, set by the completion pulse
   always @(posedge clk) begin
      if (write_done_set === 1'b1) begin
         done_flag <= 1'b1;
      end
   end
   // ------------------------------------------------
   // firmware accesses
   // ------------------------------------------------
   task automatic reg_write(input logic [8:0] a, input logic [7:0] d);
      @(posedge clk);
      repeat (pace) @(posedge clk);
      for (int i = 0; i < 400 && cpu_stall !== 1'b0; i++) @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
      // released data bus shows no stale value
      sfr_wdata <= ~d;
   endtask
   task automatic reg_read(input logic [8:0] a, output logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      @(posedge clk);
      @(posedge clk);
      #1 d = sfr_rdata;
   endtask
   task automatic start_write(input logic sel, input logic [7:0] key2);
      done_flag = 1'b0;
      // permit set by an earlier write
      reg_write(nac_pkg::ADDR_CONTROL, {sel, 7'h04});
      // key pair right before the start
      reg_write(nac_pkg::ADDR_UNLOCK, nac_pkg::KEY_FIRST);
      reg_write(nac_pkg::ADDR_UNLOCK, key2);
      reg_write(nac_pkg::ADDR_CONTROL, {sel, 7'h06});
   endtask
endmodule

// ==== tb/nac_nvm_self_access_controller_test.sv ====
// self-checking bench of the nonvolatile self-access controller
`timescale 1ns/1ps
module nac_nvm_self_access_controller_test;
   localparam int EE_N = 20;
   localparam int FL_N = 16;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic pin_reset = 1'b0;
   logic watchdog_reset = 1'b0;
   logic [1:0] pace = 2'h0;
   logic [8:0] sfr_addr;
   logic sfr_wr;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata;
   logic cpu_stall;
   logic irq_defer;
   logic write_done_set;
   logic write_busy;
   int failures = 0;
   int check_count = 0;
   integer seed = 32'h2333_95ab;
   logic [7:0] rd;
   logic stall_seen;
   logic defer_seen;
   logic [5:0] ea [4];
   logic [7:0] ed [4];
   logic [10:0] fa [3];
   logic [13:0] fd [3];

   always #5 clk = ~clk;

   nac_nvm_self_access_controller #(.EE_WRITE_CYCLES(EE_N), .FL_WRITE_CYCLES(FL_N))
   u_nac_nvm_self_access_controller (.clk(clk), .reset(reset), .pin_reset(pin_reset),
      .watchdog_reset(watchdog_reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_stall(cpu_stall),
      .irq_defer(irq_defer), .write_done_set(write_done_set), .write_busy(write_busy));
   nac_core_model u_nac_core_model (.clk(clk), .pace(pace), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .cpu_stall(cpu_stall), .write_done_set(write_done_set));

   // ------------------------------------------------
   // checking helpers
   // ------------------------------------------------
   function automatic logic [7:0] high_exp(input logic [13:0] w);
      return {nac_pkg::DATA_HIGH_PAD, w[13:8]};
   endfunction
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string what);
      chk8({7'h00, got}, {7'h00, exp}, what);
   endtask
   task automatic rchk(input logic [8:0] a, input logic [7:0] exp, input string what);
      u_nac_core_model.reg_read(a, rd);
      chk8(rd, exp, what);
   endtask
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      u_nac_core_model.reg_write(a, d);
   endtask
   task automatic set_loc(input logic [10:0] a, input logic [13:0] d);
      wr(nac_pkg::ADDR_ADDR_LOW, a[7:0]);
      wr(nac_pkg::ADDR_ADDR_HIGH, {5'h00, a[10:8]});
      wr(nac_pkg::ADDR_DATA_LOW, d[7:0]);
      wr(nac_pkg::ADDR_DATA_HIGH, {2'h3, d[13:8]});
   endtask
   task automatic wait_done(input logic exp_stall);
      stall_seen = 1'b0;
      defer_seen = 1'b0;
      for (int i = 0; i < 400 && u_nac_core_model.done_flag !== 1'b1; i++) begin
         @(posedge clk);
         #1 stall_seen = stall_seen | (cpu_stall === 1'b1);
         defer_seen = defer_seen | (irq_defer === 1'b1);
      end
      chk1(u_nac_core_model.done_flag, 1'b1, "write done");
      chk1(stall_seen, exp_stall, "core stall");
      chk1(defer_seen, exp_stall, "irq hold");
      chk1(write_busy, 1'b0, "busy after done");
      // hold lasts at most one instruction past the end of the write
      repeat (nac_pkg::CLKS_PER_INSTR) @(posedge clk);
      #1 chk1(irq_defer, 1'b0, "irq hold released");
   endtask
   task automatic try_start(input logic [7:0] c, input logic [7:0] k2, input logic extra);
      wr(nac_pkg::ADDR_UNLOCK, nac_pkg::KEY_FIRST);
      wr(nac_pkg::ADDR_UNLOCK, k2);
      if (extra) wr(nac_pkg::ADDR_ADDR_HIGH, 8'h00);
      wr(nac_pkg::ADDR_CONTROL, c);
      repeat (3) @(posedge clk);
      #1 chk1(write_busy, 1'b0, "refused start");
   endtask
   task automatic end_sim;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      rchk(nac_pkg::ADDR_CONTROL, 8'h00, "ctrl reset");
      rchk(nac_pkg::ADDR_UNLOCK, 8'h00, "unlock read");
      rchk(9'h100, 8'h00, "unmapped read");
      try_start(8'h02, nac_pkg::KEY_SECOND, 1'b0);
      try_start(8'h06, nac_pkg::KEY_SECOND, 1'b0);
      try_start(8'h06, 8'h5A, 1'b0);
      try_start(8'h06, nac_pkg::KEY_SECOND, 1'b1);
      for (int i = 0; i < 4; i++) begin
         // top bits keep the four locations distinct
         ea[i] = (i == 0) ? 6'h3F : {2'(i - 1), 4'($random(seed))};
         ed[i] = 8'($random(seed));
         pace <= 2'($random(seed));
         wr(nac_pkg::ADDR_ADDR_HIGH, 8'($random(seed)));
         set_loc({5'h00, ea[i]}, {6'h3F, ed[i]});
         u_nac_core_model.start_write(1'b0, nac_pkg::KEY_SECOND);
         if (i == 0) begin
            wr(nac_pkg::ADDR_CONTROL, 8'h84);
            rchk(nac_pkg::ADDR_CONTROL, 8'h06, "select frozen");
         end
         wait_done(1'b0);
         rchk(nac_pkg::ADDR_CONTROL, 8'h04, "ctrl after write");
      end
      pace <= 2'h0;
      for (int i = 0; i < 4; i++) begin
         wr(nac_pkg::ADDR_ADDR_HIGH, 8'hFF);
         wr(nac_pkg::ADDR_ADDR_LOW, {2'h0, ea[i]});
         wr(nac_pkg::ADDR_CONTROL, 8'h01);
         rchk(nac_pkg::ADDR_DATA_LOW, ed[i], "eeprom read");
         rchk(nac_pkg::ADDR_CONTROL, 8'h00, "read start clear");
      end
      for (int i = 0; i < 3; i++) begin
         fa[i] = (i == 0) ? 11'h7FF : {2'(i - 1), 9'($random(seed))};
         fd[i] = 14'($random(seed));
         set_loc(fa[i], fd[i]);
         rchk(nac_pkg::ADDR_DATA_HIGH, high_exp(fd[i]), "high pad");
         u_nac_core_model.start_write(1'b1, nac_pkg::KEY_SECOND);
         wait_done(1'b1);
      end
      for (int i = 0; i < 3; i++) begin
         set_loc(fa[i], 14'h0000);
         wr(nac_pkg::ADDR_CONTROL, 8'h81);
         repeat (2 * nac_pkg::CLKS_PER_INSTR + 1) @(posedge clk);
         rchk(nac_pkg::ADDR_DATA_LOW, fd[i][7:0], "flash low");
         rchk(nac_pkg::ADDR_DATA_HIGH, high_exp(fd[i]), "flash high");
      end
      for (int k = 0; k < 2; k++) begin
         set_loc(11'h015, 14'h1A5C);
         u_nac_core_model.start_write(k[0], nac_pkg::KEY_SECOND);
         repeat (5) @(posedge clk);
         if (k == 0) pin_reset <= 1'b1;
         else watchdog_reset <= 1'b1;
         @(posedge clk);
         pin_reset <= 1'b0;
         watchdog_reset <= 1'b0;
         rchk(nac_pkg::ADDR_CONTROL, {k[0], 7'h08}, "abort flag");
         rchk(nac_pkg::ADDR_ADDR_LOW, 8'h15, "addr kept");
         rchk(nac_pkg::ADDR_DATA_LOW, 8'h5C, "data kept");
      end
      wr(nac_pkg::ADDR_CONTROL, 8'h00);
      rchk(nac_pkg::ADDR_CONTROL, 8'h00, "abort cleared");
      end_sim;
   end

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim;
   end
endmodule
